// ==== rtl/slot_fifo_format_regs.svh ====
// Register offset, field positions and reset values of the slot FIFO format control
`ifndef SLOT_FIFO_FORMAT_REGS_SVH
`define SLOT_FIFO_FORMAT_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define SLOT_FMT_CTRL_OFS      8'h11
`define SLOT_FMT_CTRL_RESET    16'h1000

// ****************************************
// Field positions
// ****************************************
`define READOUT_MODE_BIT       13
`define DROP_POLICY_BIT        12
`define SECOND_FMT_HI          8
`define SECOND_FMT_LO          6
`define SECOND_ENABLE_BIT      5
`define FIRST_FMT_HI           4
`define FIRST_FMT_LO           2
`define FIRST_ENABLE_BIT       0

// ****************************************
// Format codes and word counts
// ****************************************
`define FMT_NONE               3'h0
`define FMT_SUM16              3'h1
`define FMT_SUM32              3'h2
`define FMT_CH16               3'h4
`define FMT_CH32               3'h6
`define WORDS_SUM16            4'h1
`define WORDS_SUM32            4'h2
`define WORDS_CH16             4'h4
`define WORDS_CH32             4'h8

`endif

// ==== rtl/slot_fifo_format_pkg.sv ====
// Types shared by the slot FIFO format logic
package slot_fifo_format_pkg;

   // One finished sample of one time slot
   typedef struct packed {
      logic             slot;     // 0 first slot, 1 second slot
      logic [3:0][31:0] chan;
   } sample_t;

   // Output sequencer states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EMIT = 1'b1
   } emit_state_t;

endpackage

// ==== rtl/slot_fifo_format.sv ====
// Slot FIFO format control register and sample-to-FIFO word packer
//
// Function
// R1 - Second-slot format field bits 8:6; zero stores nothing from that slot.
// R2 - Second-slot code 1 stores 16-bit four-channel sum; code 2 stores 32-bit sum.
// R3 - Second-slot code 4 stores four 16-bit channel words per sample.
// R4 - Second-slot code 6 stores four 32-bit extended channel words per sample.
// R5 - Second slot stored only if averaging factors match or first format zero.
// R6 - Bit 5 enables the second time slot.
// R7 - First-slot format field bits 4:2; zero stores nothing from that slot.
// R8 - First-slot code 1 stores 16-bit sum; code 2 stores 32-bit sum.
// R9 - First-slot code 4 stores four 16-bit words; code 6 four 32-bit words.
// R10 - Drop policy 1 discards samples while FIFO full; 0 overwrites oldest.
// R11 - Software uses only codes 0,1,2,4,6; bits 11:9 reserved.
`timescale 1ns/1ps
`include "slot_fifo_format_regs.svh"

module slot_fifo_format
   import slot_fifo_format_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          regWrEn,
   input  wire logic [7:0]    regAddr,
   input  wire logic [15:0]   regWrData,
   output logic      [15:0]   regRdData,
   input  wire logic [2:0]    firstAvgFactor,
   input  wire logic [2:0]    secondAvgFactor,
   input  wire logic          sampleValid,
   input  wire sample_t       sampleIn,
   output logic               sampleReady,
   input  wire logic          fifoFull,
   output logic               fifoWrEn,
   output logic      [15:0]   fifoWrData,
   output logic               fifoOverwrite,
   output logic               firstSlotEnable,
   output logic               secondSlotEnable
);

   // ****************************************
   // Word count per format code
   // ****************************************
   function automatic logic [3:0] word_count(input logic [2:0] fmt);
      logic [3:0] n;
      n = 4'h0;
      unique case (fmt)
         `FMT_SUM16: n = `WORDS_SUM16;
         `FMT_SUM32: n = `WORDS_SUM32;
         `FMT_CH16:  n = `WORDS_CH16;
         `FMT_CH32:  n = `WORDS_CH32;
         default:    n = 4'h0;   // Zero and reserved codes store nothing
      endcase
      return n;
   endfunction

   // ****************************************
   // Control register
   // ****************************************
   logic [15:0] ctrl_q;
   logic [15:0] regRdData_q;
   wire         ctrlHit = (regAddr == `SLOT_FMT_CTRL_OFS);

   // Whole word stored, reserved bits included, so reads return what was written
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_q      <= `SLOT_FMT_CTRL_RESET;
         regRdData_q <= 16'h0000;
      end else begin
         if (regWrEn && ctrlHit) begin
            ctrl_q <= regWrData;
         end
         regRdData_q <= ctrlHit ? ctrl_q : 16'h0000;
      end
   end

   // Field decode
   wire [2:0] secondFmt   = ctrl_q[`SECOND_FMT_HI:`SECOND_FMT_LO];   // R1
   wire [2:0] firstFmt    = ctrl_q[`FIRST_FMT_HI:`FIRST_FMT_LO];     // R7
   wire       secondOn    = ctrl_q[`SECOND_ENABLE_BIT];               // R6
   wire       firstOn     = ctrl_q[`FIRST_ENABLE_BIT];
   wire       dropPolicy  = ctrl_q[`DROP_POLICY_BIT];

   // ****************************************
   // Sample acceptance
   // ****************************************
   // Second slot only while averaging agrees or first-slot format is zero
   wire       secondStoreOk = (firstAvgFactor == secondAvgFactor) ||
                              (firstFmt == `FMT_NONE);            // R5
   wire       slotActive  = sampleIn.slot ? (secondOn && secondStoreOk) : firstOn;   // R6
   wire [2:0] slotFmt     = sampleIn.slot ? secondFmt : firstFmt;
   wire [3:0] slotWords   = slotActive ? word_count(slotFmt) : 4'h0;   // R1 R7
   wire       dropSample  = dropPolicy && fifoFull;                    // R10
   logic      sampleReady_q;   // Declared here, ahead of the acceptance decode that reads it
   wire       accept      = sampleValid && sampleReady_q;
   wire       startEmit   = accept && (slotWords != 4'h0) && !dropSample;

   // Four-channel sum, carried to 34 bits; the 32-bit form takes bits 31:0 only and drops the top carries
   wire [33:0] chanSum = {2'b00, sampleIn.chan[0]} + {2'b00, sampleIn.chan[1]} +
                         {2'b00, sampleIn.chan[2]} + {2'b00, sampleIn.chan[3]};

   // ****************************************
   // Word packing, most significant half first for 32-bit values
   // ****************************************
   logic [7:0][15:0] packed_d;
   always_comb begin
      packed_d = '0;
      unique case (slotFmt)
         `FMT_SUM16: packed_d[0] = chanSum[15:0];                        // R2 R8
         `FMT_SUM32: begin
            packed_d[0] = chanSum[31:16];                                // R2 R8
            packed_d[1] = chanSum[15:0];
         end
         `FMT_CH16: begin
            for (int i = 0; i < 4; i++) begin
               packed_d[i] = sampleIn.chan[i][15:0];                     // R3 R9
            end
         end
         `FMT_CH32: begin
            for (int i = 0; i < 4; i++) begin
               packed_d[2*i]   = sampleIn.chan[i][31:16];               // R4 R9
               packed_d[2*i+1] = sampleIn.chan[i][15:0];
            end
         end
         default: packed_d = '0;
      endcase
   end

   // ****************************************
   // Output sequencer
   // ****************************************
   emit_state_t      state_q;
   logic [7:0][15:0] words_q;
   logic [3:0]       count_q;
   logic [3:0]       idx_q;
   logic             fifoWrEn_q;
   logic [15:0]      fifoWrData_q;
   logic             fifoOverwrite_q;

   wire lastWord = (idx_q == count_q - 4'h1);

   // One word a cycle; a sample is never split by a drop once started
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q         <= ST_IDLE;
         words_q         <= '0;
         count_q         <= 4'h0;
         idx_q           <= 4'h0;
         sampleReady_q   <= 1'b1;
         fifoWrEn_q      <= 1'b0;
         fifoWrData_q    <= 16'h0000;
         fifoOverwrite_q <= 1'b0;
      end else begin
         fifoWrEn_q      <= 1'b0;
         fifoOverwrite_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (startEmit) begin
                  state_q       <= ST_EMIT;
                  words_q       <= packed_d;
                  count_q       <= slotWords;
                  idx_q         <= 4'h0;
                  sampleReady_q <= 1'b0;
               end
            end
            ST_EMIT: begin
               fifoWrEn_q      <= 1'b1;
               fifoWrData_q    <= words_q[idx_q[2:0]];
               fifoOverwrite_q <= !dropPolicy && fifoFull;   // R10
               idx_q           <= idx_q + 4'h1;
               if (lastWord) begin
                  state_q       <= ST_IDLE;
                  sampleReady_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic firstSlotEnable_q;
   logic secondSlotEnable_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         firstSlotEnable_q  <= 1'b0;
         secondSlotEnable_q <= 1'b0;
      end else begin
         firstSlotEnable_q  <= firstOn;
         secondSlotEnable_q <= secondOn;   // R6
      end
   end

   assign regRdData        = regRdData_q;
   assign sampleReady      = sampleReady_q;
   assign fifoWrEn         = fifoWrEn_q;
   assign fifoWrData       = fifoWrData_q;
   assign fifoOverwrite    = fifoOverwrite_q;
   assign firstSlotEnable  = firstSlotEnable_q;
   assign secondSlotEnable = secondSlotEnable_q;

endmodule

// ==== bench/slot_fifo_format_properties.sv ====
// Concurrent checks on the ports of the slot FIFO format block
`timescale 1ns/1ps
module slot_fifo_format_properties (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        regWrEn,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic        sampleValid,
   input wire logic        sampleReady,
   input wire logic        fifoWrEn,
   input wire logic        fifoOverwrite,
   input wire logic        secondSlotEnable
);
   // ****************************************
   // One domain, so one clocking for all
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ctrl_readback_a: assert property (((regWrEn && regAddr == 8'h11) ##1 (!regWrEn && regAddr == 8'h11))
      |=> regRdData == $past(regWrData, 2)) else $error("control readback wrong");
   unmapped_read_a: assert property (regAddr != 8'h11 |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   slot_enable_copy_a: assert property (((regWrEn && regAddr == 8'h11) ##1 !regWrEn)
      |=> secondSlotEnable == $past(regWrData[5], 2)) else $error("slot enable copy wrong");
   accept_to_word_a: assert property (((sampleValid && sampleReady) ##1 !sampleReady)
      |=> fifoWrEn) else $error("first word late");
   word_gap_a: assert property ($fell(sampleReady) |-> !fifoWrEn ##1 fifoWrEn)
      else $error("first word not one cycle after ready fell");
   word_cause_a: assert property ($rose(fifoWrEn) |-> !$past(sampleReady))
      else $error("word without accepted sample");
   burst_bound_a: assert property (fifoWrEn [*8] |=> !fifoWrEn)
      else $error("burst longer than eight words");
   overwrite_flag_a: assert property (fifoOverwrite |-> fifoWrEn)
      else $error("overwrite flag without word");
   ready_return_a: assert property (!sampleReady |-> ##[1:9] sampleReady)
      else $error("ready stuck low");
endmodule
bind slot_fifo_format slot_fifo_format_properties chk (.sys_clk, .rst, .regWrEn, .regAddr,
   .regWrData, .regRdData, .sampleValid, .sampleReady, .fifoWrEn, .fifoOverwrite, .secondSlotEnable);

// ==== bench/tb.sv ====
// Self-checking random bench for the slot FIFO format block
`timescale 1ns/1ps
module tb import slot_fifo_format_pkg::*;;
   logic        sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, sampleValid = 1'b0, fifoFull = 1'b0;
   logic [7:0]  regAddr = 8'h11;
   logic [15:0] regWrData = 16'h0000, regRdData, fifoWrData;
   logic [2:0]  firstAvgFactor = 3'h0, secondAvgFactor = 3'h0;
   sample_t     sampleIn = '0;
   logic        sampleReady, fifoWrEn, fifoOverwrite, firstSlotEnable, secondSlotEnable;
   logic [15:0] gotQ[$], expQ[$];
   logic [31:0] rng = 32'h00000034;
   int          n_fail = 0, total_checks = 0, cyc = 0, nOvr = 0;
   slot_fifo_format dut (.sys_clk, .rst, .regWrEn, .regAddr, .regWrData, .regRdData,
      .firstAvgFactor, .secondAvgFactor, .sampleValid, .sampleIn, .sampleReady, .fifoFull,
      .fifoWrEn, .fifoWrData, .fifoOverwrite, .firstSlotEnable, .secondSlotEnable);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Words the FIFO should see, high half first
   function automatic void expect_words(logic [2:0] f, sample_t s);
      logic [31:0] sum;
      sum = s.chan[0] + s.chan[1] + s.chan[2] + s.chan[3];
      if (f == 3'h1) expQ.push_back(sum[15:0]);
      if (f == 3'h2) expQ = {sum[31:16], sum[15:0]};
      for (int i = 0; i < 4; i++) begin
         if (f == 3'h4) expQ.push_back(s.chan[i][15:0]);
         if (f == 3'h6) expQ = {expQ, s.chan[i][31:16], s.chan[i][15:0]};
      end
   endfunction
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(logic [15:0] d);
      @(posedge sys_clk);
      regWrEn <= 1'b1;
      regWrData <= d;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      repeat (2) @(posedge sys_clk);
      check(regRdData, exp);
      regAddr <= 8'h11;
   endtask
   // Program, offer one random sample, then compare the whole burst
   task automatic send(logic slot, logic [2:0] f, logic [15:0] ctrl);
      sample_t s;
      s.slot = slot;
      for (int i = 0; i < 4; i++) s.chan[i] = xs();
      wr(ctrl);
      @(posedge sys_clk);
      sampleValid <= 1'b1;
      sampleIn <= s;
      @(posedge sys_clk);
      while (sampleReady !== 1'b1) @(posedge sys_clk);
      sampleValid <= 1'b0;
      expQ = {};
      gotQ = {};
      expect_words(f, s);
      repeat (14) @(posedge sys_clk);
      check(16'(gotQ.size()), 16'(expQ.size()));
      foreach (expQ[i]) check(gotQ[i], expQ[i]);
      check({14'h0, firstSlotEnable, secondSlotEnable}, {14'h0, ctrl[0], ctrl[5]});
   endtask
   // Clock, monitor and hang guard
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (fifoWrEn === 1'b1) gotQ.push_back(fifoWrData);
      if (fifoOverwrite === 1'b1) nOvr++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      logic [2:0] fmts[5];
      fmts = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h11, 16'h1000);
      rd(8'h3C, 16'h0000);
      for (int k = 0; k < 10; k++) begin
         firstAvgFactor <= 3'(xs());
         secondAvgFactor <= 3'(xs());
         if (k < 5) send(1'b0, fmts[k], {4'h1, 3'h0, 3'h0, 1'b0, fmts[k], 2'h1});
         else send(1'b1, fmts[k-5], {4'h1, 3'h0, fmts[k-5], 1'b1, 3'h0, 2'h0});
      end
      // Mismatched averaging with first slot storing blocks the second slot
      firstAvgFactor <= 3'h2;
      secondAvgFactor <= 3'h5;
      send(1'b1, 3'h0, {4'h1, 3'h0, 3'h1, 1'b1, 3'h1, 2'h1});
      secondAvgFactor <= 3'h2;
      send(1'b1, 3'h1, {4'h1, 3'h0, 3'h1, 1'b1, 3'h1, 2'h1});
      send(1'b1, 3'h0, {4'h1, 3'h0, 3'h1, 1'b0, 3'h0, 2'h1});
      fifoFull <= 1'b1;
      send(1'b0, 3'h0, {4'h1, 6'h00, 1'b0, 3'h2, 2'h1});
      send(1'b0, 3'h2, {4'h0, 6'h00, 1'b0, 3'h2, 2'h1});
      check(16'(nOvr), 16'h0002);
      rd(8'h11, 16'h0009);
      tally_and_finish();
   end
endmodule
